/* src/blt_consts.svh */
`ifndef BLT_CONSTS_SVH
`define BLT_CONSTS_SVH
// Clock rate and the training timeout, in their own units.
`define BLT_CLK_KHZ 10000
`define BLT_TIMEOUT_MS 500
`define BLT_TIMEOUT_CYC (`BLT_TIMEOUT_MS * `BLT_CLK_KHZ)
// Frame layout, in bit times counted from the first delimiter bit.
`define BLT_FRAME_LAST 13'h111F
`define BLT_DELIM_HALF 13'h0010
`define BLT_DELIM_END 13'h0020
`define BLT_STAT_START 13'h00A0
`define BLT_SEQ_START 13'h0120
`define BLT_DELIM_WORD 32'hFFFF0000
// Receive offsets, counted from the first bit after the delimiter.
`define BLT_RX_CTRL_LAST 13'h007F
`define BLT_RX_STAT_LAST 13'h00FF
`define BLT_SUB_LAST 3'h7
// Control and status word fields.
`define BLT_CTRL_MASK 16'h303F
`define BLT_STAT_MASK 16'h003F
`define BLT_STAT_RX_MASK 16'h803F
`define BLT_RDY_BIT 15
`define BLT_PRESET_BIT 13
`define BLT_INIT_BIT 12
// Pattern generator.
`define BLT_PRBS_MSB 10
`define BLT_PRBS_TAP 8
`define BLT_SEED_ONE 11'h001
// Register byte offsets.
`define BLT_REG_CFG 5'h00
`define BLT_REG_TX_CTRL 5'h04
`define BLT_REG_TX_STAT 5'h08
`define BLT_REG_STATUS 5'h0C
`define BLT_REG_RX_CTRL 5'h10
`define BLT_REG_RX_STAT 5'h14
`define BLT_REG_IRQ_STAT 5'h18
`define BLT_REG_IRQ_MASK 5'h1C
// Configuration register fields and reset value.
`define BLT_CFG_EN 0
`define BLT_CFG_RESTART 1
`define BLT_CFG_EQDONE 2
`define BLT_SEED_LSB 16
`define BLT_SEED_MSB 26
`define BLT_CFG_MASK 32'h07FF0005
`define BLT_CFG_RST 32'h00010000
// Interrupt status bits.
`define BLT_IRQ_NORMAL 0
`define BLT_IRQ_FAIL 1
`define BLT_IRQ_LOCK 2
`define BLT_IRQ_UNLOCK 3
`endif

/* src/blt_pkg.sv */
package blt_pkg;
   // Training sequencer states, Gray coded along idle, train, data.
   typedef enum logic [1:0] {
      BLT_IDLE = 2'h0,
      BLT_TRAIN = 2'h1,
      BLT_SEND = 2'h3,
      BLT_FAIL = 2'h2
   } blt_state_type;
   // Bit position within a training frame.
   typedef logic [12:0] blt_pos_type;
   // Training timeout counter.
   typedef logic [22:0] blt_tmr_type;
   // Fields received from the partner, as presented to the host.
   typedef struct packed {
      logic rx_preset_bit;
      logic rx_init_bit;
      logic [1:0] rx_post_tap_request;
      logic [1:0] rx_main_tap_request;
      logic [1:0] rx_pre_tap_request;
      logic [1:0] rx_post_tap_report;
      logic [1:0] rx_main_tap_report;
      logic [1:0] rx_pre_tap_report;
   } blt_rx_fields_type;
endpackage

/* src/blt_link_train.sv */
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "blt_consts.svh"
module blt_link_train
   import blt_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYC = `BLT_TIMEOUT_CYC
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic irq_o,
   input wire logic rx_bit_i,
   output logic tx_bit_o,
   output logic mission_mode_o,
   output logic lane_normal_data_o,
   output logic train_active_o,
   output logic train_timeout_o,
   output logic train_frame_sync_o,
   output logic rx_frame_start_pulse_o,
   output blt_rx_fields_type rx_fields_o
);

   // Merges write data into an old value under the byte enables.
   function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return res;
   endfunction

   // Picks the word bit sent at a bit offset; eight bit times per bit.
   function automatic logic word_bit(input logic [15:0] word,
      input blt_pos_type off);
      return word[4'hF - off[6:3]];
   endfunction

   logic ack_ff; // Second cycle of a bus access.
   logic acc; // Access completes at this edge.
   logic wr_acc; // A write takes effect at this edge.
   logic [31:0] readdata_ff; // Read data, valid when waitrequest drops.
   logic [31:0] rd_val; // Read multiplexer.
   logic [31:0] cfg_ff; // Enable, receiver done and seed.
   logic restart_ff; // One-cycle restart pulse from software.
   logic [15:0] tx_ctrl_reg_ff; // Host control block to send.
   logic [15:0] tx_stat_reg_ff; // Host status fields to send.
   logic [3:0] irq_stat_ff; // Sticky event bits.
   logic [3:0] irq_mask_ff; // Interrupt enables.
   logic [3:0] irq_ev; // Events this cycle.
   logic [3:0] w1c; // Bits being cleared by software.
   logic [31:0] wd_zero; // Write data with unselected bytes zeroed.
   logic train_en; // Training enabled.
   logic eq_done; // Host receiver equalizer finished.
   logic [10:0] seed; // Pattern generator seed.
   blt_state_type state_ff; // Training sequencer state.
   blt_state_type nxt_state; // Next sequencer state.
   blt_tmr_type tmr_ff; // Time spent in training.
   logic tmo_hit; // Training period expired.
   logic tx_go; // Transmitter stays in a running frame.
   blt_pos_type tx_pos_ff; // Current transmit bit position.
   logic [10:0] tx_lfsr_ff; // Training sequence generator.
   logic [15:0] tx_ctrl_lat_ff; // Control word frozen for the frame.
   logic [15:0] tx_stat_lat_ff; // Status word frozen for the frame.
   logic nxt_tx_bit; // Bit for the current position.
   logic tx_bit_ff; // Registered line bit.
   logic rx_meta_ff; // First synchroniser stage.
   logic rx_sync_ff; // Second synchroniser stage.
   logic [31:0] rx_shift_ff; // Last 32 received bits.
   blt_pos_type rx_cnt_ff; // Bits since the last accepted delimiter.
   logic delim_hit; // Delimiter pattern seen.
   logic expect_end; // Next delimiter is due now.
   logic accept; // Delimiter accepted as a frame start.
   logic rx_seen_ff; // One delimiter accepted, tracking frames.
   logic rx_lock_ff; // Two delimiters a frame apart.
   logic lock_set; // Lock gained this cycle.
   logic lock_clr; // Lock lost this cycle.
   logic [15:0] rx_ctrl_acc_ff; // Control word being assembled.
   logic [15:0] rx_stat_acc_ff; // Status word being assembled.
   logic [15:0] rx_ctrl_ff; // Last complete control word.
   logic [15:0] rx_stat_ff; // Last complete status word.
   logic sof_ff; // Frame start pulse.
   logic normal_ff; // Data state reached.
   logic active_ff; // Training in progress.
   logic fail_ff; // Training timed out.
   logic mission_ff; // Lane in mission operation.

   // One wait state per access keeps the read data registered.
   assign acc = (avs_read_i | avs_write_i) & ack_ff;
   assign wr_acc = acc & avs_write_i;
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_ff;
   assign avs_readdata_o = readdata_ff;
   assign train_en = cfg_ff[`BLT_CFG_EN];
   assign eq_done = cfg_ff[`BLT_CFG_EQDONE];
   assign seed = cfg_ff[`BLT_SEED_MSB:`BLT_SEED_LSB];
   // Merged once, so pulse and clear bits see only enabled byte lanes.
   assign wd_zero = be_merge(32'h00000000, avs_writedata_i,
      avs_byteenable_i);

   // Wait-state tracker: low again after each completed access.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read_i | avs_write_i) & ~ack_ff;
      end
   end

   // Read multiplexer; unmapped addresses read as zero.
   always_comb begin
      if (avs_address_i == `BLT_REG_CFG) begin
         rd_val = cfg_ff;
      end else if (avs_address_i == `BLT_REG_TX_CTRL) begin
         rd_val = {16'h0000, tx_ctrl_reg_ff};
      end else if (avs_address_i == `BLT_REG_TX_STAT) begin
         rd_val = {16'h0000, tx_stat_reg_ff};
      end else if (avs_address_i == `BLT_REG_STATUS) begin
         rd_val = {27'h0, mission_ff, train_frame_sync_o,
            fail_ff, active_ff, normal_ff};
      end else if (avs_address_i == `BLT_REG_RX_CTRL) begin
         rd_val = {16'h0000, rx_ctrl_ff};
      end else if (avs_address_i == `BLT_REG_RX_STAT) begin
         rd_val = {16'h0000, rx_stat_ff};
      end else if (avs_address_i == `BLT_REG_IRQ_STAT) begin
         rd_val = {28'h0000000, irq_stat_ff};
      end else if (avs_address_i == `BLT_REG_IRQ_MASK) begin
         rd_val = {28'h0000000, irq_mask_ff};
      end else begin
         rd_val = 32'h00000000;
      end
   end

   // Read data is captured in the wait cycle and stands for the answer.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         readdata_ff <= 32'h00000000;
      end else if (avs_read_i & ~ack_ff) begin
         readdata_ff <= rd_val;
      end
   end

   // Software-written registers; restart is a write-one pulse.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cfg_ff <= `BLT_CFG_RST;
         restart_ff <= 1'b0;
         tx_ctrl_reg_ff <= 16'h0000;
         tx_stat_reg_ff <= 16'h0000;
         irq_mask_ff <= 4'h0;
      end else begin
         restart_ff <= wr_acc && avs_address_i == `BLT_REG_CFG &&
            wd_zero[`BLT_CFG_RESTART];
         if (wr_acc && avs_address_i == `BLT_REG_CFG) begin
            cfg_ff <= be_merge(cfg_ff, avs_writedata_i,
               avs_byteenable_i) & `BLT_CFG_MASK;
         end
         if (wr_acc && avs_address_i == `BLT_REG_TX_CTRL) begin
            tx_ctrl_reg_ff <= 16'(be_merge({16'h0000, tx_ctrl_reg_ff},
               avs_writedata_i, avs_byteenable_i)) & `BLT_CTRL_MASK;
         end
         if (wr_acc && avs_address_i == `BLT_REG_TX_STAT) begin
            tx_stat_reg_ff <= 16'(be_merge({16'h0000, tx_stat_reg_ff},
               avs_writedata_i, avs_byteenable_i)) & `BLT_STAT_MASK;
         end
         if (wr_acc && avs_address_i == `BLT_REG_IRQ_MASK) begin
            irq_mask_ff <= 4'(be_merge({28'h0000000, irq_mask_ff},
               avs_writedata_i, avs_byteenable_i));
         end
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle.
   assign irq_ev[`BLT_IRQ_NORMAL] = nxt_state == BLT_SEND &&
      state_ff != BLT_SEND;
   assign irq_ev[`BLT_IRQ_FAIL] = nxt_state == BLT_FAIL &&
      state_ff != BLT_FAIL;
   assign irq_ev[`BLT_IRQ_LOCK] = lock_set & ~rx_lock_ff;
   assign irq_ev[`BLT_IRQ_UNLOCK] = lock_clr & rx_lock_ff;
   assign w1c = (wr_acc && avs_address_i == `BLT_REG_IRQ_STAT) ?
      wd_zero[3:0] : 4'h0;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_stat_ff <= 4'h0;
      end else begin
         irq_stat_ff <= irq_ev | (irq_stat_ff & ~w1c);
      end
   end
   assign irq_o = |(irq_stat_ff & irq_mask_ff);

   // Sequencer: disable forces idle, restart forces a fresh start.
   assign tmo_hit = tmr_ff == blt_tmr_type'(TIMEOUT_CYC - 1);
   always_comb begin
      nxt_state = state_ff;
      if (!train_en) begin
         nxt_state = BLT_IDLE;
      end else if (restart_ff) begin
         nxt_state = BLT_TRAIN;
      end else begin
         case (state_ff)
            BLT_IDLE: begin
               nxt_state = BLT_TRAIN;
            end
            BLT_TRAIN: begin
               if (tmo_hit) begin
                  nxt_state = BLT_FAIL;
               end else if (eq_done && rx_lock_ff &&
                  rx_stat_ff[`BLT_RDY_BIT]) begin
                  nxt_state = BLT_SEND;
               end
            end
            default: begin
               nxt_state = state_ff;
            end
         endcase
      end
   end

   // State, timer and registered status outputs.
   assign tx_go = state_ff == BLT_TRAIN && nxt_state == BLT_TRAIN &&
      !restart_ff;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_ff <= BLT_IDLE;
         tmr_ff <= '0;
         normal_ff <= 1'b0;
         active_ff <= 1'b0;
         fail_ff <= 1'b0;
         mission_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         tmr_ff <= tx_go ? tmr_ff + 1'b1 : '0;
         normal_ff <= nxt_state == BLT_SEND;
         active_ff <= nxt_state == BLT_TRAIN;
         fail_ff <= nxt_state == BLT_FAIL;
         mission_ff <= nxt_state == BLT_IDLE ||
            nxt_state == BLT_SEND;
      end
   end
   assign lane_normal_data_o = normal_ff;
   assign train_active_o = active_ff;
   assign train_timeout_o = fail_ff;
   assign mission_mode_o = mission_ff;

   // Transmit position; the frame restarts whenever training restarts.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !tx_go || tx_pos_ff == `BLT_FRAME_LAST) begin
         tx_pos_ff <= '0;
      end else begin
         tx_pos_ff <= tx_pos_ff + 1'b1;
      end
   end

   // Fields are frozen at frame start so a host update never tears.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_ctrl_lat_ff <= 16'h0000;
         tx_stat_lat_ff <= 16'h0000;
         tx_lfsr_ff <= `BLT_SEED_ONE;
      end else if (tx_pos_ff == '0) begin
         tx_ctrl_lat_ff <= tx_ctrl_reg_ff;
         tx_stat_lat_ff <= tx_stat_reg_ff |
            {eq_done, 15'h0000};
         // A zero seed would lock the generator, so it is replaced.
         tx_lfsr_ff <= (seed == '0) ? `BLT_SEED_ONE : seed;
      end else if (tx_pos_ff >= `BLT_SEQ_START) begin
         tx_lfsr_ff <= {tx_lfsr_ff[`BLT_PRBS_MSB-1:0],
            tx_lfsr_ff[`BLT_PRBS_MSB] ^ tx_lfsr_ff[`BLT_PRBS_TAP]};
      end
   end

   // Frame content by position.
   always_comb begin
      if (tx_pos_ff < `BLT_DELIM_HALF) begin
         nxt_tx_bit = 1'b1;
      end else if (tx_pos_ff < `BLT_DELIM_END) begin
         nxt_tx_bit = 1'b0;
      end else if (tx_pos_ff < `BLT_STAT_START) begin
         nxt_tx_bit = word_bit(tx_ctrl_lat_ff,
            tx_pos_ff - `BLT_DELIM_END);
      end else if (tx_pos_ff < `BLT_SEQ_START) begin
         nxt_tx_bit = word_bit(tx_stat_lat_ff,
            tx_pos_ff - `BLT_STAT_START);
      end else begin
         nxt_tx_bit = tx_lfsr_ff[`BLT_PRBS_MSB];
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_bit_ff <= 1'b0;
      end else begin
         tx_bit_ff <= (state_ff == BLT_TRAIN) & nxt_tx_bit;
      end
   end
   assign tx_bit_o = tx_bit_ff;

   // Line input synchroniser and delimiter search.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_meta_ff <= 1'b0;
         rx_sync_ff <= 1'b0;
         rx_shift_ff <= 32'h00000000;
      end else begin
         rx_meta_ff <= rx_bit_i;
         rx_sync_ff <= rx_meta_ff;
         rx_shift_ff <= {rx_shift_ff[30:0], rx_sync_ff};
      end
   end
   assign delim_hit = rx_shift_ff == `BLT_DELIM_WORD;
   assign expect_end = rx_cnt_ff == `BLT_FRAME_LAST;
   // Once locked, only a delimiter at the frame boundary counts.
   assign accept = delim_hit & (~rx_lock_ff | expect_end);
   assign lock_set = delim_hit & expect_end & rx_seen_ff;
   assign lock_clr = expect_end & ~delim_hit;

   // Frame tracking, lock and field capture.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_cnt_ff <= '0;
         rx_seen_ff <= 1'b0;
         rx_lock_ff <= 1'b0;
         sof_ff <= 1'b0;
         rx_ctrl_acc_ff <= 16'h0000;
         rx_stat_acc_ff <= 16'h0000;
         rx_ctrl_ff <= 16'h0000;
         rx_stat_ff <= 16'h0000;
      end else begin
         rx_cnt_ff <= (accept | expect_end) ? '0 : rx_cnt_ff + 1'b1;
         rx_seen_ff <= accept | (rx_seen_ff & ~lock_clr);
         rx_lock_ff <= lock_set | (rx_lock_ff & ~lock_clr);
         sof_ff <= accept;
         if (rx_seen_ff && rx_cnt_ff[2:0] == `BLT_SUB_LAST) begin
            if (rx_cnt_ff <= `BLT_RX_CTRL_LAST) begin
               rx_ctrl_acc_ff[4'hF - rx_cnt_ff[6:3]] <= rx_shift_ff[0];
            end else if (rx_cnt_ff <= `BLT_RX_STAT_LAST) begin
               rx_stat_acc_ff[4'hF - rx_cnt_ff[6:3]] <= rx_shift_ff[0];
            end
         end
         if (rx_lock_ff && rx_cnt_ff == `BLT_RX_STAT_LAST) begin
            rx_ctrl_ff <= rx_ctrl_acc_ff & `BLT_CTRL_MASK;
            rx_stat_ff <= {rx_stat_acc_ff[15:1], rx_shift_ff[0]} &
               `BLT_STAT_RX_MASK;
         end
      end
   end
   assign rx_frame_start_pulse_o = sof_ff;
   assign train_frame_sync_o = rx_lock_ff & (state_ff != BLT_IDLE);
   // Received fields straight from the captured words.
   assign rx_fields_o = {rx_ctrl_ff[`BLT_PRESET_BIT],
      rx_ctrl_ff[`BLT_INIT_BIT], rx_ctrl_ff[5:0],
      rx_stat_ff[5:0]};

   // Disabled training always lands in idle.
   chk_disable_idle: assert property (@(posedge clk_sys_i) disable iff
      (rst_i) !train_en |=> state_ff == BLT_IDLE && mission_mode_o)
      else $error("idle not reached while disabled");
   // Restart gives a fresh frame and timer.
   chk_restart_fresh: assert property (@(posedge clk_sys_i) disable iff
      (rst_i) train_en && restart_ff |=> state_ff == BLT_TRAIN &&
      tmr_ff == '0 && tx_pos_ff == '0)
      else $error("restart did not restart training");
   // Data state shows on the normal-data output, not active.
   chk_normal_out: assert property (@(posedge clk_sys_i) disable iff
      (rst_i) nxt_state == BLT_SEND |=> lane_normal_data_o &&
      !train_active_o)
      else $error("normal data output wrong");
   // Active follows the training state.
   chk_active_level: assert property (@(posedge clk_sys_i) disable iff
      (rst_i) train_active_o == (state_ff == BLT_TRAIN))
      else $error("training active output wrong");
   // Timeout ends training with failure.
   chk_timeout_fail: assert property (@(posedge clk_sys_i) disable iff
      (rst_i) state_ff == BLT_TRAIN && tmo_hit && train_en &&
      !restart_ff |=> train_timeout_o && !train_active_o)
      else $error("timeout did not fail training");
   // Frame start pulse never lasts two cycles.
   chk_sof_pulse: assert property (@(posedge clk_sys_i) disable iff
      (rst_i) rx_frame_start_pulse_o |=> !rx_frame_start_pulse_o)
      else $error("frame start pulse too long");
   // Frame length wraps exactly at the last bit.
   chk_frame_len: assert property (@(posedge clk_sys_i) disable iff
      (rst_i) tx_go && tx_pos_ff == `BLT_FRAME_LAST |=> tx_pos_ff == '0)
      else $error("frame length wrong");
   // Delimiter turns from ones to zeros at its midpoint.
   chk_delim_edge: assert property (@(posedge clk_sys_i) disable iff
      (rst_i) state_ff == BLT_TRAIN && tx_pos_ff == `BLT_DELIM_HALF
      |-> tx_bit_ff ##1 !tx_bit_ff)
      else $error("delimiter edge wrong");
   // First control bit sent is bit fifteen.
   chk_ctrl_msb: assert property (@(posedge clk_sys_i) disable iff
      (rst_i) state_ff == BLT_TRAIN && tx_pos_ff == `BLT_DELIM_END
      |=> tx_bit_ff == tx_ctrl_lat_ff[`BLT_RDY_BIT])
      else $error("control word not msb first");

endmodule

/* tb/blt_partner.sv */
`timescale 1ns/1ps
// Far end of the lane. It sends training frames back to back while send_i
// is high. When idle it toggles the line, so no stale level is left there.
module blt_partner (
   input wire logic clk_sys_i,
   input wire logic send_i,
   input wire logic [15:0] ctrl_i,
   input wire logic [15:0] stat_i,
   output logic line_o
);
   logic [12:0] pos_ff = 13'h0000; // Bit time within the frame.
   logic [10:0] prbs_ff = 11'h7FF; // Training sequence, never all zero.
   logic line_ff = 1'b0; // Line level being driven.
   logic [12:0] off; // Bit time counted after the delimiter.
   assign line_o = line_ff;
   assign off = pos_ff - 13'h0020;
   // One line bit per clock, changed just after the edge.
   always @(posedge clk_sys_i) begin
      if (!send_i) begin
         pos_ff <= 13'h0000;
         line_ff <= ~line_ff;
      end else begin
         pos_ff <= (pos_ff == 13'h111F) ? 13'h0000 :
            pos_ff + 13'h0001;
         if (pos_ff < 13'h0020) begin
            line_ff <= (pos_ff < 13'h0010);
         end else if (off < 13'h0100) begin
            // Each word bit stands for eight bit times, top bit first.
            line_ff <= off[7] ? stat_i[4'hF - off[6:3]] :
               ctrl_i[4'hF - off[6:3]];
         end else begin
            line_ff <= prbs_ff[10];
            prbs_ff <= {prbs_ff[9:0], prbs_ff[10] ^ prbs_ff[8]};
         end
      end
   end
endmodule

/* tb/test_blt_link_train.sv */
`timescale 1ns/1ps
`include "blt_consts.svh"
module test_blt_link_train;
   import blt_pkg::*;
   localparam int TMO = 30000; // Short timeout keeps the run brief.
   localparam int FRM = 4384; // Bit times in one frame.
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic [31:0] rdat;
   logic wreq, irq, rxb, txb, miss, norm, act, tmo, sync, sof;
   logic [3:0] st; // Status outputs, indexed by wait_hi.
   blt_rx_fields_type fld;
   logic send = 1'b0;
   logic [15:0] pc, ps, tc, ts;
   logic eq = 1'b0; // Equalizer-done bit as last written.
   logic [10:0] seed;
   logic [63:0] rq[$]; // Pending reads: mask above, value below.
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   int t0 = 0;
   int lsof = 0;
   logic [31:0] tsh = 32'h0;
   logic [15:0] tse = 16'h0000; // Status word of the frame on the line.
   int tcnt = 0;
   logic thave = 1'b0;
   logic actq = 1'b0;
   logic sofq = 1'b0;
   assign st = {sync, tmo, act, norm};
   always #50 clk = ~clk;
   blt_link_train #(.TIMEOUT_CYC(TMO)) uut (.clk_sys_i(clk), .rst_i(rst),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_byteenable_i(4'hF), .avs_writedata_i(wd), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .irq_o(irq), .rx_bit_i(rxb), .tx_bit_o(txb),
      .mission_mode_o(miss), .lane_normal_data_o(norm),
      .train_active_o(act), .train_timeout_o(tmo),
      .train_frame_sync_o(sync), .rx_frame_start_pulse_o(sof),
      .rx_fields_o(fld));
   blt_partner peer (.clk_sys_i(clk), .send_i(send), .ctrl_i(pc),
      .stat_i(ps), .line_o(rxb));
   task automatic chk(input string nm, input logic [31:0] e, s);
      n_tests++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         miscompares++;
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // One bus transfer; a read leaves its expectation in the queue first.
   task automatic bus(input logic w, input logic [4:0] a,
         input logic [31:0] d, input logic [31:0] m);
      if (!w) rq.push_back({m, d & m});
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_hi(input int b, input int n);
      while (st[b] !== 1'b1 && n > 0) begin
         @(posedge clk);
         n--;
      end
      chk("status wait", 32'h1, {31'h0, st[b]});
   endtask
   // Random word without adjacent ones, so no false delimiter can form.
   function automatic logic [15:0] nadj(input logic [15:0] r, m);
      return r & ~(r << 1) & m;
   endfunction
   // Read watcher and hang guard.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (rd && wreq === 1'b0 && rq.size() > 0) begin
         chk("readdata", rq[0][31:0], rdat & rq[0][63:32]);
         void'(rq.pop_front());
      end
      if (cyc == 90000) begin
         miscompares++;
         stop_test();
      end
   end
   // Transmit stream: delimiter spacing and the two repeated words.
   always @(posedge clk) begin
      tsh <= {tsh[30:0], txb};
      tcnt <= tcnt + 1;
      actq <= act;
      if (!act) begin
         thave <= 1'b0;
      end else if ({tsh[30:0], txb} == 32'hFFFF0000) begin
         if (thave) chk("frame bits", FRM, tcnt + 1);
         thave <= 1'b1;
         tcnt <= 0;
         // The status word is frozen per frame, so its ready bit is too.
         tse <= {eq, ts[14:0]};
      end else if (thave && actq && tcnt < 256) begin
         chk("tx bit", {31'h0, tcnt < 128 ? tc[15 - tcnt / 8] :
            tse[15 - (tcnt - 128) / 8]}, {31'h0, txb});
      end
   end
   // Frame start pulses: one cycle wide and frame spaced once locked.
   always @(posedge clk) begin
      sofq <= sof;
      if (sof) begin
         if (sofq) chk("sof width", 32'h0, 32'h1);
         if (sync && lsof > 0) chk("sof gap", FRM, cyc - lsof);
         lsof <= cyc;
      end
   end
   initial begin
      void'($urandom(72));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(0, `BLT_REG_CFG, 32'h00010000, '1);
      bus(0, `BLT_REG_STATUS, 32'h10, 32'h1F);
      bus(0, 5'h02, 32'h0, '1);
      chk("irq idle", 32'h0, {31'h0, irq});
      tc = nadj(16'($urandom), 16'h303E);
      ts = nadj(16'($urandom), 16'h003F);
      pc = nadj(16'($urandom), 16'h303E);
      ps = nadj(16'($urandom), 16'h003F) | 16'h8000;
      seed = 11'($urandom % 2047) + 11'h001;
      bus(1, `BLT_REG_TX_CTRL, {16'h0, tc}, 0);
      bus(1, `BLT_REG_TX_STAT, {16'h0, ts}, 0);
      bus(1, `BLT_REG_IRQ_MASK, 32'h1, 0);
      send <= 1'b1;
      bus(1, `BLT_REG_CFG, {5'h0, seed, 16'h1}, 0);
      wait_hi(1, 10);
      bus(0, `BLT_REG_STATUS, 32'h2, 32'h17);
      wait_hi(3, 2 * FRM + 200);
      repeat (FRM) @(posedge clk);
      chk("rx fields", {pc[13:12], pc[5:0], ps[5:0]},
         fld);
      bus(0, `BLT_REG_RX_CTRL, {16'h0, pc}, 32'h303F);
      bus(0, `BLT_REG_RX_STAT, {16'h0, ps}, 32'h803F);
      // The host reports its receiver done only after the fields settled.
      eq = 1'b1;
      bus(1, `BLT_REG_CFG, {5'h0, seed, 16'h5}, 0);
      wait_hi(0, 100);
      chk("active in data", 32'h0, {31'h0, act});
      chk("mission in data", 32'h1, {31'h0, miss});
      chk("irq raised", 32'h1, {31'h0, irq});
      bus(0, `BLT_REG_IRQ_STAT, 32'h5, 32'h5);
      bus(1, `BLT_REG_IRQ_MASK, 32'h0, 0);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1, `BLT_REG_IRQ_MASK, 32'h3, 0);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      bus(1, `BLT_REG_IRQ_STAT, 32'h1, 0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      eq = 1'b0;
      bus(1, `BLT_REG_CFG, {5'h0, seed, 16'h3}, 0);
      t0 = cyc;
      wait_hi(1, 10);
      chk("normal on restart", 32'h0, {31'h0, norm});
      send <= 1'b0;
      wait_hi(2, TMO + 50);
      chk("timeout span", 32'h1, {31'h0, cyc - t0 >= TMO - 5 &&
         cyc - t0 <= TMO + 5});
      chk("active on fail", 32'h0, {31'h0, act});
      chk("irq on fail", 32'h1, {31'h0, irq});
      bus(0, `BLT_REG_IRQ_STAT, 32'h2, 32'h2);
      bus(1, `BLT_REG_CFG, 32'h0, 0);
      // State outputs follow the enable one cycle after it is written.
      @(posedge clk);
      chk("mission idle", 32'h1, {31'h0, miss});
      chk("timeout cleared", 32'h0, {31'h0, tmo});
      chk("tx idle", 32'h0, {31'h0, txb});
      stop_test();
   end
endmodule
